// *** src/ecsm_cfg.svh ***
/*
 * Constants of the exchange context slot manager: sizes, null values, field widths.
 * Assumes inclusion by bare name from the package and the core.
 */
`ifndef ECSM_CFG_SVH
`define ECSM_CFG_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define ECSM_NSLOT   4
`define ECSM_SLOT_W  2
`define ECSM_XID_W   8
`define ECSM_PORT_W  24
`define ECSM_CB_W    8
`define ECSM_CTX_W   32

// ----------------------------------------
// values
// ----------------------------------------
`define ECSM_NULL_XID 8'hff
`define ECSM_NULL_AS  8'hff
`define ECSM_SYNC_N   3

`endif

// *** src/ecsm_core.sv ***
/*
 * Channel-side exchange context slot manager: slot allocation, control block
 * lock and fetch, first-frame header, routing by exchange id, write-back.
 * Assumes one clock, a storage port that locks on fetch, and a frame link
 * whose tx side holds a frame until tx_ready_i.
 */
// Notes on behaviour
// - one port pair chosen per operation
// - lock control block, copy into slot
// - originator exchange id equals slot index
// - first frame: responder id, associator null
// - control block id in originator associator
// - first frame sets new-id flag
// - hold exchange until ack; later frames bare
// - route received frames by originator id only
// - disconnect writes back, operation still active
// - free slot and id after write-back
// - termination writes back, operation ended
// - reconnection allocates slot, reloads control block
// - any channel accepts any reconnection
// - dedicated class needs established connection
// - slot context only while connected
// - one outstanding operation per control block
`timescale 1ns/100ps
`default_nettype none
`include "ecsm_cfg.svh"

module ecsm_core (
    // clock and reset
    input  wire logic                     sys_clk_i,
    input  wire logic                     sys_rst_i,
    // operation start
    input  wire logic                     start_valid_i,
    input  wire ecsm_pkg::ecsm_start_t    start_i,
    output logic                          start_ready_o,
    // later data frames of an exchange
    input  wire logic                     data_valid_i,
    input  wire logic [`ECSM_SLOT_W-1:0]  data_slot_i,
    output logic                          data_ready_o,
    // received frames
    input  wire logic                     rx_valid_i,
    input  wire ecsm_pkg::ecsm_frame_t    rx_frame_i,
    output logic                          rx_ready_o,
    output logic                          route_valid_o,
    output logic [`ECSM_SLOT_W-1:0]       route_slot_o,
    output logic                          route_err_o,
    // transmitted frames
    output logic                          tx_valid_o,
    output ecsm_pkg::ecsm_frame_t         tx_frame_o,
    input  wire logic                     tx_ready_i,
    // main storage
    output logic                          mem_valid_o,
    output ecsm_pkg::ecsm_mem_req_t       mem_req_o,
    input  wire logic                     mem_ack_i,
    input  wire logic [`ECSM_CTX_W-1:0]   mem_rdata_i,
    // context update by the channel program engine
    input  wire logic                     ctx_wr_valid_i,
    input  wire logic [`ECSM_SLOT_W-1:0]  ctx_wr_slot_i,
    input  wire logic [`ECSM_CTX_W-1:0]   ctx_wr_data_i,
    // connection state
    input  wire logic                     dedicated_i,
    input  wire logic                     conn_up_i,
    // slot status
    output logic [`ECSM_NSLOT-1:0]        slot_busy_o,
    output logic [`ECSM_NSLOT-1:0]        slot_hold_o
);
    import ecsm_pkg::*;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    ecsm_state_t             state;
    ecsm_state_t             next_state;
    logic [`ECSM_CTX_W-1:0]  slot_ctx [`ECSM_NSLOT];
    logic [`ECSM_CB_W-1:0]   slot_cb [`ECSM_NSLOT];
    logic [`ECSM_XID_W-1:0]  slot_rxid [`ECSM_NSLOT];
    logic [`ECSM_CB_W-1:0]   slot_roas [`ECSM_NSLOT];
    ecsm_ports_t             slot_ports [`ECSM_NSLOT];
    logic [`ECSM_SLOT_W-1:0] cur_slot;
    logic                    cur_reconn;
    logic [`ECSM_SYNC_N-1:0] conn_sync;
    logic                    conn_ok;

    // ----------------------------------------
    // connection pin synchroniser
    // ----------------------------------------
    // stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            conn_sync <= '0;
            conn_ok   <= 1'b0;
        end else begin
            conn_sync <= {conn_sync[1:0], conn_up_i};
            if (conn_sync[1] == conn_sync[2]) begin
                conn_ok <= conn_sync[2];
            end
        end
    end

    // ----------------------------------------
    // request decode
    // ----------------------------------------
    logic                    have_free;
    logic [`ECSM_SLOT_W-1:0] free_slot;
    logic                    link_ok;
    logic                    cb_held;
    logic [`ECSM_SLOT_W-1:0] rx_slot;
    logic                    rx_known;
    logic                    rx_reconn;
    logic                    rx_ack_hit;
    logic                    take_rx;
    logic                    take_start;
    logic                    take_data;

    // lowest free slot wins; the scan is short so a plain loop is cheap
    always_comb begin
        have_free = 1'b0;
        free_slot = '0;
        cb_held   = 1'b0;
        for (int i = `ECSM_NSLOT - 1; i >= 0; i--) begin
            if (!slot_busy_o[i]) begin
                have_free = 1'b1;
                free_slot = i[`ECSM_SLOT_W-1:0];
            end
            if (slot_busy_o[i] && slot_cb[i] == start_i.cb_id) begin
                cb_held = 1'b1;
            end
        end
    end

    always_comb begin
        link_ok    = !dedicated_i || conn_ok;
        rx_slot    = rx_frame_i.originator_exchange_id[`ECSM_SLOT_W-1:0];
        rx_known   = (rx_frame_i.originator_exchange_id < 8'(`ECSM_NSLOT)) && slot_busy_o[rx_slot];
        rx_reconn  = rx_frame_i.assoc_present && !rx_frame_i.is_ack
                     && rx_frame_i.originator_exchange_id == `ECSM_NULL_XID;
        rx_ack_hit = rx_frame_i.is_ack && rx_known && slot_hold_o[rx_slot];
        // the rx gate repeats have_free and link_ok, the start gate only cb_held, so a lagging ready never steals a slot for a reconnect or a held block
        take_rx    = rx_valid_i && rx_ready_o && (!rx_reconn || (have_free && link_ok));
        take_start = start_valid_i && start_ready_o && !take_rx && !cb_held;
        take_data  = data_valid_i && data_ready_o && !take_rx && !take_start
                     && slot_busy_o[data_slot_i] && !slot_hold_o[data_slot_i];
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ECSM_ST_IDLE: begin
                if (take_rx && rx_reconn) begin
                    next_state = ECSM_ST_FETCH;
                end else if (take_rx && rx_known && !rx_frame_i.is_ack
                             && (rx_frame_i.invalidate || rx_frame_i.last)) begin
                    next_state = ECSM_ST_WB;
                end else if (take_start) begin
                    next_state = ECSM_ST_FETCH;
                end else if (take_data) begin
                    next_state = ECSM_ST_TX;
                end
            end
            ECSM_ST_FETCH: begin
                if (mem_ack_i) begin
                    next_state = ECSM_ST_TX;
                end
            end
            ECSM_ST_TX: begin
                if (tx_ready_i) begin
                    next_state = ECSM_ST_IDLE;
                end
            end
            ECSM_ST_WB: begin
                if (mem_ack_i) begin
                    next_state = ECSM_ST_IDLE;
                end
            end
            default: begin
                next_state = ECSM_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ECSM_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // current operation
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cur_slot   <= '0;
            cur_reconn <= 1'b0;
        end else if (state == ECSM_ST_IDLE) begin
            cur_reconn <= take_rx && rx_reconn;
            if (take_rx && rx_reconn) begin
                cur_slot <= free_slot;
            end else if (take_rx) begin
                cur_slot <= rx_slot;
            end else if (take_start) begin
                cur_slot <= free_slot;
            end else if (take_data) begin
                cur_slot <= data_slot_i;
            end
        end
    end

    // ----------------------------------------
    // slot table
    // ----------------------------------------
    // context lives here only between fetch and write-back
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            slot_busy_o <= '0;
            slot_hold_o <= '0;
            for (int i = 0; i < `ECSM_NSLOT; i++) begin
                slot_ctx[i]   <= '0;
                slot_cb[i]    <= '0;
                slot_rxid[i]  <= `ECSM_NULL_XID;
                slot_roas[i]  <= `ECSM_NULL_AS;
                slot_ports[i] <= '0;
            end
        end else begin
            if (ctx_wr_valid_i && slot_busy_o[ctx_wr_slot_i]) begin
                slot_ctx[ctx_wr_slot_i] <= ctx_wr_data_i;
            end
            if (take_rx && rx_reconn) begin
                slot_busy_o[free_slot] <= 1'b1;
                slot_cb[free_slot]     <= rx_frame_i.originator_operation_associator;
                slot_rxid[free_slot]   <= rx_frame_i.responder_exchange_id;
                slot_roas[free_slot]   <= rx_frame_i.responder_operation_associator;
                slot_ports[free_slot]  <= '{rx_frame_i.ports.destination_port_id,
                                            rx_frame_i.ports.source_port_id};
            end else if (take_rx && rx_ack_hit) begin
                slot_hold_o[rx_slot] <= 1'b0;
                slot_rxid[rx_slot]   <= rx_frame_i.responder_exchange_id;
            end else if (take_start) begin
                slot_busy_o[free_slot] <= 1'b1;
                slot_cb[free_slot]     <= start_i.cb_id;
                slot_rxid[free_slot]   <= `ECSM_NULL_XID;
                slot_roas[free_slot]   <= `ECSM_NULL_AS;
                slot_ports[free_slot]  <= start_i.ports;
            end
            if (state == ECSM_ST_FETCH && mem_ack_i) begin
                slot_ctx[cur_slot] <= mem_rdata_i;
                if (!cur_reconn) begin
                    slot_hold_o[cur_slot] <= 1'b1;
                end
            end
            if (state == ECSM_ST_WB && mem_ack_i) begin
                slot_busy_o[cur_slot] <= 1'b0;
                slot_hold_o[cur_slot] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // handshake and routing outputs
    // ----------------------------------------
    // ready is registered, so it trails a freed slot by one cycle
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            start_ready_o <= 1'b0;
            data_ready_o  <= 1'b0;
            rx_ready_o    <= 1'b0;
            route_valid_o <= 1'b0;
            route_slot_o  <= '0;
            route_err_o   <= 1'b0;
        end else begin
            // the held-block test looks at start_i before valid, so a requester that sets it
            // a cycle ahead is refused from the cycle in which it raises valid
            start_ready_o <= next_state == ECSM_ST_IDLE && have_free && link_ok
                             && !take_start && !cb_held;
            data_ready_o  <= next_state == ECSM_ST_IDLE;
            // before a frame is seen a full table keeps ready low; a non-reconnect frame lifts it
            rx_ready_o    <= next_state == ECSM_ST_IDLE
                             && ((rx_valid_i && !rx_reconn) || (have_free && link_ok));
            route_valid_o <= take_rx && !rx_reconn && rx_known && state == ECSM_ST_IDLE;
            route_slot_o  <= rx_slot;
            route_err_o   <= take_rx && !rx_reconn && !rx_known && state == ECSM_ST_IDLE;
        end
    end

    // ----------------------------------------
    // frame and storage requests
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_valid_o  <= 1'b0;
            tx_frame_o  <= '0;
            mem_valid_o <= 1'b0;
            mem_req_o   <= '0;
        end else begin
            if (state == ECSM_ST_IDLE && next_state == ECSM_ST_FETCH) begin
                mem_valid_o     <= 1'b1; // lock and fetch
                mem_req_o.op    <= ECSM_MEM_LOCK_FETCH;
                mem_req_o.cb_id <= rx_reconn && take_rx ? rx_frame_i.originator_operation_associator
                                                        : start_i.cb_id;
                mem_req_o.data  <= '0;
                mem_req_o.still_active <= 1'b1;
            end else if (state == ECSM_ST_IDLE && next_state == ECSM_ST_WB) begin
                mem_valid_o     <= 1'b1;
                mem_req_o.op    <= ECSM_MEM_WRITE_BACK;
                mem_req_o.cb_id <= slot_cb[rx_slot];
                mem_req_o.data  <= slot_ctx[rx_slot];
                mem_req_o.still_active <= !rx_frame_i.last;
            end else if (mem_ack_i) begin
                mem_valid_o <= 1'b0;
            end
            if (state == ECSM_ST_FETCH && mem_ack_i) begin
                tx_valid_o <= 1'b1;
                tx_frame_o <= '0;
                tx_frame_o.ports <= slot_ports[cur_slot];
                tx_frame_o.originator_exchange_id <= 8'(cur_slot);
                tx_frame_o.originator_operation_associator <= slot_cb[cur_slot];
                tx_frame_o.responder_operation_associator  <= slot_roas[cur_slot];
                tx_frame_o.responder_exchange_id <= slot_rxid[cur_slot];
                tx_frame_o.is_ack        <= cur_reconn;
                tx_frame_o.assoc_present <= !cur_reconn;
                tx_frame_o.new_xid       <= !cur_reconn;
            end else if (state == ECSM_ST_IDLE && take_data) begin
                tx_valid_o <= 1'b1;
                tx_frame_o <= '0;
                tx_frame_o.ports <= slot_ports[data_slot_i];
                tx_frame_o.originator_exchange_id <= 8'(data_slot_i);
                tx_frame_o.responder_exchange_id  <= slot_rxid[data_slot_i]; // bare header
            end else if (tx_ready_i) begin
                tx_valid_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking ck @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence seq_disc;
        state == ECSM_ST_IDLE && take_rx && rx_known && !rx_frame_i.is_ack
        && rx_frame_i.invalidate && !rx_frame_i.last;
    endsequence
    sequence seq_term;
        state == ECSM_ST_IDLE && take_rx && rx_known && !rx_frame_i.is_ack && rx_frame_i.last;
    endsequence
    sequence seq_first;
        tx_valid_o && tx_frame_o.assoc_present && !tx_frame_o.is_ack;
    endsequence

    AST_FIRST_NULL: assert property (seq_first |-> tx_frame_o.responder_exchange_id == `ECSM_NULL_XID
        && tx_frame_o.responder_operation_associator == `ECSM_NULL_AS) else $error("first frame ids not null");
    AST_XID_SLOT: assert property (seq_first |-> tx_frame_o.originator_exchange_id == 8'(cur_slot))
        else $error("exchange id differs from slot");
    AST_ASSOC_CB: assert property (seq_first |-> tx_frame_o.originator_operation_associator == slot_cb[cur_slot])
        else $error("associator differs from control block");
    AST_NEW_XID: assert property (seq_first |-> tx_frame_o.new_xid)
        else $error("new id flag missing");
    AST_HOLD: assert property (state == ECSM_ST_IDLE && take_data |=> tx_valid_o && !tx_frame_o.assoc_present
        && !slot_hold_o[cur_slot]) else $error("frame sent while held");
    AST_DISC_WB: assert property (seq_disc |=> mem_valid_o && mem_req_o.op == ECSM_MEM_WRITE_BACK
        && mem_req_o.still_active) else $error("disconnect write-back wrong");
    AST_TERM_WB: assert property (seq_term |=> mem_valid_o && mem_req_o.op == ECSM_MEM_WRITE_BACK
        && !mem_req_o.still_active) else $error("termination write-back wrong");
    AST_FREE: assert property (state == ECSM_ST_WB && mem_ack_i |=> !slot_busy_o[$past(cur_slot)]
        && !slot_hold_o[$past(cur_slot)] && state == ECSM_ST_IDLE) else $error("slot not freed");
    AST_RECONN: assert property (state == ECSM_ST_IDLE && take_rx && rx_reconn |-> !slot_busy_o[free_slot]
        ##1 slot_busy_o[cur_slot] && mem_valid_o && mem_req_o.op == ECSM_MEM_LOCK_FETCH) else $error("reconnect slot wrong");
    AST_LOCK: assert property (state == ECSM_ST_IDLE && take_start |=> mem_valid_o
        && mem_req_o.op == ECSM_MEM_LOCK_FETCH && slot_busy_o[cur_slot]) else $error("no lock fetch");
    AST_ROUTE: assert property (state == ECSM_ST_IDLE && take_rx && !rx_reconn && rx_known
        |=> route_valid_o && route_slot_o == $past(rx_slot)) else $error("routing wrong");

endmodule

`default_nettype wire

// *** src/ecsm_pkg.sv ***
/*
 * Types of the exchange context slot manager: request, frame and storage carriers.
 * Assumes ecsm_cfg.svh is on the include path.
 */
`default_nettype none
`include "ecsm_cfg.svh"

package ecsm_pkg;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic [`ECSM_PORT_W-1:0] source_port_id;
        logic [`ECSM_PORT_W-1:0] destination_port_id;
    } ecsm_ports_t;

    typedef struct packed {
        ecsm_ports_t           ports;
        logic [`ECSM_CB_W-1:0] cb_id;
    } ecsm_start_t;

    typedef struct packed {
        ecsm_ports_t            ports;
        logic [`ECSM_XID_W-1:0] originator_exchange_id;
        logic [`ECSM_XID_W-1:0] responder_exchange_id;
        logic                   is_ack;
        logic                   assoc_present;
        logic [`ECSM_CB_W-1:0]  originator_operation_associator;
        logic [`ECSM_CB_W-1:0]  responder_operation_associator;
        logic                   new_xid;
        logic                   invalidate;
        logic                   last;
    } ecsm_frame_t;

    typedef enum logic {
        ECSM_MEM_LOCK_FETCH,
        ECSM_MEM_WRITE_BACK
    } ecsm_mem_op_t;

    typedef struct packed {
        ecsm_mem_op_t           op;
        logic [`ECSM_CB_W-1:0]  cb_id;
        logic [`ECSM_CTX_W-1:0] data;
        logic                   still_active;
    } ecsm_mem_req_t;

    typedef enum logic [1:0] {
        ECSM_ST_IDLE,
        ECSM_ST_FETCH,
        ECSM_ST_TX,
        ECSM_ST_WB
    } ecsm_state_t;

endpackage

`default_nettype wire

// *** testbench/ecsm_core_tb.sv ***
/* bench of the slot manager: storage model, disk model, table of starts.
   assumes one request at a time, each once the design is idle. */
`timescale 1ns/100ps
`default_nettype none
module ecsm_core_tb;
    import ecsm_pkg::*;
    logic          clk, rst, sv, dv, cw, ded, cup, mack, ok, srdy, drdy;
    logic          rxv, rxr, rv, re, txv, txr, mv;
    logic [1:0]    ds, cs, rs, s;
    logic [3:0]    busy, hold, rt;
    logic [7:0]    c;
    logic [31:0]   cd, mrd;
    ecsm_start_t   st;
    ecsm_frame_t   rxf, txf, g;
    ecsm_mem_req_t mq, mgot;
    int            miscompares = 0, tests_run = 0, i, k;
    logic [9:0]    rows [4] = '{{8'h03, 2'd0}, {8'h17, 2'd1}, {8'h29, 2'd2}, {8'h3c, 2'd3}};
    ecsm_core uut (.sys_clk_i(clk), .sys_rst_i(rst), .start_valid_i(sv), .start_i(st), .start_ready_o(srdy),
        .data_valid_i(dv), .data_slot_i(ds), .data_ready_o(drdy), .rx_valid_i(rxv), .rx_frame_i(rxf),
        .rx_ready_o(rxr), .route_valid_o(rv), .route_slot_o(rs), .route_err_o(re), .tx_valid_o(txv),
        .tx_frame_o(txf), .tx_ready_i(txr), .mem_valid_o(mv), .mem_req_o(mq), .mem_ack_i(mack),
        .mem_rdata_i(mrd), .ctx_wr_valid_i(cw), .ctx_wr_slot_i(cs), .ctx_wr_data_i(cd), .dedicated_i(ded),
        .conn_up_i(cup), .slot_busy_o(busy), .slot_hold_o(hold));
    ecsm_disk_model disk (.sys_clk_i(clk), .tx_valid_i(txv), .tx_frame_i(txf), .tx_ready_o(txr),
        .rx_valid_o(rxv), .rx_frame_o(rxf), .rx_ready_i(rxr));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // storage answers a cycle late; fetched words carry the block id
    initial forever begin
        @(posedge clk);
        #1;
        if (mv) begin
            @(posedge clk);
            #1 mack = 1'b1;
            mgot = mq;
            mrd = {24'h5a5a00, mq.cb_id};
            @(posedge clk);
            #1 mack = 1'b0;
            mrd = ~mrd;
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // bounded wait for idle, then keep the last frame the disk took
    task automatic idle_wait();
        int n;
        for (n = 0; n < 40 && !drdy; n++) begin
            @(posedge clk);
            #1;
        end
        check(drdy, 1'b1);
        if (!drdy)
            print_verdict();
        g = disk.got;
    endtask
    // ready is registered, so the request settles one cycle before valid
    task automatic start(input logic [7:0] cb);
        int n;
        st = {24'h010203, 16'h0a0b, cb, cb};
        ok = 1'b0;
        @(posedge clk);
        #1 sv = 1'b1;
        for (n = 0; n < 8 && !ok; n++) begin
            ok = srdy;
            @(posedge clk);
            #1;
        end
        sv = 1'b0;
        idle_wait();
    endtask
    task automatic data(input logic [1:0] sl);
        ds = sl;
        dv = 1'b1;
        @(posedge clk);
        #1 dv = 1'b0;
        idle_wait();
    endtask
    // flg holds association header present, invalidate, last
    task automatic rx(input logic [7:0] ox, input logic [2:0] flg);
        ecsm_frame_t f;
        f = {24'h0c0d0e, 24'h010203, ox, 8'h66, 2'b00, 16'h0327, 3'b000};
        {f.assoc_present, f.invalidate, f.last} = flg;
        disk.send(f, ok);
        rt = {rv, rs, re};
        check(ok, 1'b1);
        idle_wait();
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
    initial begin
        {rst, sv, dv, cw, ded, cup, mack} = 7'b1000000;
        {ds, cs, cd, mrd, st} = '0;
        repeat (16) @(posedge clk);
        check({srdy, txv, mv, busy, hold}, 11'h0);
        #1 rst = 1'b0;
        idle_wait();
        $display("reset test done");
        for (i = 0; i < 4; i++) begin
            {c, s} = rows[i];
            start(c);
            k = disk.n_got;
            check({ok, busy[i], hold[i]}, 3'b111);
            check({mgot.op, mgot.cb_id}, {ECSM_MEM_LOCK_FETCH, c});
            check(g.ports, st.ports);
            check(g.originator_exchange_id, s);
            check({g.responder_exchange_id, g.responder_operation_associator}, 16'hffff);
            check(g.originator_operation_associator, c);
            check(disk.keep_as, c);
            check({g.new_xid, g.assoc_present}, 2'b11);
            data(s);
            check(disk.n_got, k);
            disk.ack(ok);
            check({ok, rv, rs}, {2'b11, s});
            idle_wait();
            data(s);
            check({hold[i], g.new_xid, g.assoc_present, g.originator_exchange_id}, {3'b000, 6'h0, s});
            check(g.responder_exchange_id, 8'h5a);
            $display("row %0d done", i);
        end
        start(8'h40);
        check(ok, 1'b0);
        rx(8'h02, 3'b000);
        check(rt, 4'b1100);
        rx(8'h05, 3'b000);
        check(rt[0], 1'b1);
        $display("routing test done");
        cs = 2'd1;
        cd = 32'hc0ffee01;
        cw = 1'b1;
        @(posedge clk);
        #1 cw = 1'b0;
        rx(8'h01, 3'b010);
        check(mgot, {ECSM_MEM_WRITE_BACK, 8'h17, 32'hc0ffee01, 1'b1});
        check(busy, 4'b1101);
        start(8'h03);
        check(ok, 1'b0);
        start(8'h17);
        check(g.originator_exchange_id, 8'h01);
        disk.ack(ok);
        idle_wait();
        rx(8'h00, 3'b001);
        check(mgot, {ECSM_MEM_WRITE_BACK, 8'h03, 32'h5a5a0003, 1'b0});
        check(busy[0], 1'b0);
        $display("write-back test done");
        disk.dly = 2;
        rx(8'hff, 3'b100);
        check({busy[0], mgot.op, mgot.cb_id}, {1'b1, ECSM_MEM_LOCK_FETCH, 8'h03});
        check({g.is_ack, g.new_xid, g.assoc_present, g.originator_exchange_id}, 11'h400);
        check(g.responder_exchange_id, 8'h66);
        $display("reconnect test done");
        ded = 1'b1;
        rx(8'h02, 3'b001);
        start(8'h50);
        check(ok, 1'b0);
        cup = 1'b1;
        start(8'h50);
        check(ok, 1'b1);
        $display("dedicated test done");
        rst = 1'b1;
        #2 check({busy, hold, txv, mv, srdy}, 11'h0);
        print_verdict();
    end
endmodule
`default_nettype wire

// *** testbench/ecsm_disk_model.sv ***
/* disk port model across the frame link: takes frames, sends frames.
   assumes the bench calls send and ack one at a time. */
`timescale 1ns/100ps
`default_nettype none
module ecsm_disk_model #(
    parameter logic [7:0] RESP_XID = 8'h5a
) (
    // frame link
    input  wire logic                  sys_clk_i,
    input  wire logic                  tx_valid_i,
    input  wire ecsm_pkg::ecsm_frame_t tx_frame_i,
    output logic                       tx_ready_o,
    output logic                       rx_valid_o,
    output ecsm_pkg::ecsm_frame_t      rx_frame_o,
    input  wire logic                  rx_ready_i
);
    import ecsm_pkg::*;
    ecsm_frame_t got;       // last frame taken
    logic [7:0]  keep_as;   // originator associator, kept for the operation
    int          dly   = 0; // extra cycles before a frame is taken
    int          n_got = 0;
    // take each frame after dly cycles, so a slow link stalls the design
    initial begin
        tx_ready_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_frame_o = '0;
        forever begin
            @(posedge sys_clk_i);
            #1;
            if (tx_valid_i) begin
                repeat (dly) begin
                    @(posedge sys_clk_i);
                    #1;
                end
                tx_ready_o = 1'b1;
                got = tx_frame_i;
                n_got++;
                if (got.new_xid)
                    keep_as = got.originator_operation_associator;
                @(posedge sys_clk_i);
                #1 tx_ready_o = 1'b0;
            end
        end
    end
    // hold a frame until taken; the released line shows its inverse
    task automatic send(input ecsm_frame_t f, output logic ok);
        int i;
        ok = 1'b0;
        // let an edge pass so that valid drops between two frames
        @(posedge sys_clk_i);
        #1;
        rx_frame_o = f;
        rx_valid_o = 1'b1;
        for (i = 0; i < 20 && !ok; i++) begin
            ok = rx_ready_i;
            @(posedge sys_clk_i);
            #1;
        end
        rx_valid_o = 1'b0;
        rx_frame_o = ~f;
    endtask
    // answer a first frame with our own exchange id
    task automatic ack(output logic ok);
        ecsm_frame_t a;
        a = '0;
        a.is_ack = 1'b1;
        a.ports = {got.ports.destination_port_id, got.ports.source_port_id};
        a.originator_exchange_id = got.originator_exchange_id;
        a.responder_exchange_id = RESP_XID;
        send(a, ok);
    endtask
endmodule
`default_nettype wire
